// ==== rtl/dftc_dma_top.sv ====
// DMA engine whose FIFO thresholds, burst mode, width and wait states are
// set by the data configuration register, reached over classic Wishbone.
// Assumes memory answers a cycle with mem_rdy_i, and rx/tx streams are
// synchronous to clk_i.
//
// Behaviour
// - Wait field adds zero to three T2 states
// - Width bit selects 16-bit or 32-bit transfers
// - Empty/fill mode: run until rx empty, tx full
// - Block mode: run until threshold amount moved; transmit here stops at the free FIFO space when that is no larger
// - Receive request only after threshold reached
// - Receive threshold is 4, 8, 16, 24 bytes
// - Block receive writes exactly the threshold amount
// - Transmit requests bus when below threshold
// - Transmit threshold is 8, 16, 24, 28 bytes
// - Block transmit burst reads the threshold amount; the code reads the free FIFO space instead when that is no larger
// - Burst reads only what fills the FIFO
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module dftc_dma_top import dftc_pkg::*; (
  input wire logic clk_i, // 250 MHz clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte enables
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic mem_cyc_o, // memory cycle active
  output logic mem_we_o, // memory write
  output logic mem_wide_o, // 32-bit memory transfer
  output logic [31:0] mem_addr_o, // memory byte address
  output logic [31:0] mem_wdata_o, // memory write data
  input wire logic [31:0] mem_rdata_i, // memory read data
  input wire logic mem_rdy_i, // memory ready at end of T2
  input wire logic rx_valid_i, // receive word valid
  input wire logic [31:0] rx_data_i, // receive word
  output logic rx_ready_o, // receive FIFO can take a word
  output logic tx_valid_o, // transmit word valid
  output logic [31:0] tx_data_o, // transmit word
  input wire logic tx_ready_i // transmit consumer ready
);

  logic [7:0] cfg_ff, nxt_cfg;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [31:0] rx_addr_ff, nxt_rx_addr, tx_addr_ff, nxt_tx_addr;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic req;

  dftc_state_t state_ff, nxt_state;
  logic dir_tx_ff, nxt_dir_tx;
  logic [CNT_W-1:0] beats_ff, nxt_beats;
  logic [1:0] wcnt_ff, nxt_wcnt;
  logic mem_cyc_ff, nxt_mem_cyc, mem_we_ff, nxt_mem_we, mem_wide_ff, nxt_mem_wide;
  logic [31:0] mem_addr_ff, nxt_mem_addr, mem_wdata_ff, nxt_mem_wdata;
  logic rx_ready_ff, nxt_rx_ready;

  logic wide, block;
  logic [1:0] wait_sel;
  logic [CNT_W-1:0] cap, rx_thr, tx_thr, rx_count, tx_count, space;
  logic [31:0] data_mask, step;
  logic rx_pop, rx_push, tx_push, adv_rx, adv_tx, cont;
  logic [CNT_W:0] nxt_rx_level;

  dftc_stream_if rx_in();
  dftc_stream_if rx_out();
  dftc_stream_if tx_in();
  dftc_stream_if tx_mid();
  dftc_stream_if tx_ob();

  function automatic logic [CNT_W-1:0] to_units(input logic [BYTE_W-1:0] bytes,
                                                input logic w);
    to_units = w ? bytes[6:2] : bytes[5:1];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[i*8 +: 8] = val[i*8 +: 8];
      end
    end
  endfunction

  assign wide = cfg_ff[CFG_DW_BIT];
  assign block = cfg_ff[CFG_BMS_BIT];
  assign wait_sel = cfg_ff[CFG_WAIT_LSB +: 2];
  assign cap = wide ? CAP_LONG : CAP_WORD;
  assign step = wide ? STEP_LONG : STEP_WORD;
  assign data_mask = wide ? MASK_LONG : MASK_WORD;
  assign rx_thr = to_units(RX_THR_BYTES[cfg_ff[CFG_RFT_LSB +: 2]], wide);
  assign tx_thr = to_units(TX_THR_BYTES[cfg_ff[CFG_TFT_LSB +: 2]], wide);
  assign space = cap - tx_count;

  assign rx_in.valid = rx_valid_i & rx_ready_ff;
  assign rx_in.data = rx_data_i & data_mask;
  assign rx_out.ready = rx_pop;
  assign rx_push = rx_in.valid & rx_in.ready;
  assign tx_in.valid = tx_push;
  assign tx_in.data = mem_rdata_i & data_mask;
  assign tx_ob.ready = tx_ready_i;

  dftc_fifo u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cap_i(cap),
    .in_s(rx_in),
    .out_s(rx_out),
    .count_o(rx_count)
  );

  dftc_fifo u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cap_i(cap),
    .in_s(tx_in),
    .out_s(tx_mid),
    .count_o(tx_count)
  );

  dftc_skid u_tx_skid (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_s(tx_mid),
    .out_s(tx_ob)
  );

  // Register bus: ack one cycle after the request, write lands at the edge that ends the ack cycle.
  assign req = wb_cyc_i & wb_stb_i;

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_ctrl = ctrl_ff;
    nxt_rx_addr = rx_addr_ff;
    nxt_tx_addr = tx_addr_ff;
    nxt_ack = req & ~ack_ff;
    nxt_dat = dat_ff;
    if (adv_rx) begin
      nxt_rx_addr = rx_addr_ff + step;
    end
    if (adv_tx) begin
      nxt_tx_addr = tx_addr_ff + step;
    end
    if (req && !ack_ff) begin
      unique case (wb_adr_i)
        OFS_DATA_CFG: nxt_dat = {24'h000000, cfg_ff};
        OFS_CONTROL: nxt_dat = {30'h00000000, ctrl_ff};
        OFS_STATUS: nxt_dat = {14'h0000, dir_tx_ff, mem_cyc_ff, 3'h0, tx_count,
                               3'h0, rx_count};
        OFS_RX_ADDR: nxt_dat = rx_addr_ff;
        OFS_TX_ADDR: nxt_dat = tx_addr_ff;
        default: nxt_dat = 32'h00000000;
      endcase
    end
    // A software address write wins over an advance in the same cycle.
    if (req && ack_ff && wb_we_i) begin
      unique case (wb_adr_i)
        OFS_DATA_CFG: begin
          if (wb_sel_i[0]) begin
            nxt_cfg = wb_dat_i[7:0];
          end
        end
        OFS_CONTROL: begin
          if (wb_sel_i[0]) begin
            nxt_ctrl = wb_dat_i[1:0];
          end
        end
        OFS_RX_ADDR: nxt_rx_addr = merge(rx_addr_ff, wb_dat_i, wb_sel_i);
        OFS_TX_ADDR: nxt_tx_addr = merge(tx_addr_ff, wb_dat_i, wb_sel_i);
        default: nxt_cfg = cfg_ff;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= CFG_RESET;
      ctrl_ff <= CTRL_RESET;
      rx_addr_ff <= 32'h00000000;
      tx_addr_ff <= 32'h00000000;
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      cfg_ff <= nxt_cfg;
      ctrl_ff <= nxt_ctrl;
      rx_addr_ff <= nxt_rx_addr;
      tx_addr_ff <= nxt_tx_addr;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  // DMA sequencer. Receive has priority; a burst always runs to its end,
  // so clearing an enable takes effect only between bursts.
  always_comb begin
    nxt_state = state_ff;
    nxt_dir_tx = dir_tx_ff;
    nxt_beats = beats_ff;
    nxt_wcnt = wcnt_ff;
    nxt_mem_cyc = mem_cyc_ff;
    nxt_mem_we = mem_we_ff;
    nxt_mem_wide = mem_wide_ff;
    nxt_mem_addr = mem_addr_ff;
    nxt_mem_wdata = mem_wdata_ff;
    rx_pop = 1'b0;
    tx_push = 1'b0;
    adv_rx = 1'b0;
    adv_tx = 1'b0;
    cont = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (ctrl_ff[CTRL_RX_BIT] && rx_count != 5'h00 && rx_count >= rx_thr) begin
          nxt_dir_tx = 1'b0;
          nxt_beats = block ? rx_thr : rx_count;
          nxt_state = ST_T1;
          nxt_mem_cyc = 1'b1;
          nxt_mem_we = 1'b1;
          nxt_mem_wide = wide;
          nxt_mem_addr = rx_addr_ff;
          nxt_mem_wdata = rx_out.data;
          rx_pop = 1'b1;
        end else if (ctrl_ff[CTRL_TX_BIT] && tx_count < tx_thr && tx_count < cap) begin
          nxt_dir_tx = 1'b1;
          nxt_beats = (block && tx_thr < space) ? tx_thr : space;
          nxt_state = ST_T1;
          nxt_mem_cyc = 1'b1;
          nxt_mem_we = 1'b0;
          nxt_mem_wide = wide;
          nxt_mem_addr = tx_addr_ff;
        end
      end
      ST_T1: begin
        nxt_state = ST_T2;
        nxt_wcnt = wait_sel;
      end
      ST_T2: begin
        if (wcnt_ff != 2'h0) begin
          nxt_wcnt = wcnt_ff - 2'h1;
        end else if (mem_rdy_i) begin
          tx_push = dir_tx_ff;
          adv_rx = ~dir_tx_ff;
          adv_tx = dir_tx_ff;
          nxt_beats = beats_ff - 5'h01;
          if (dir_tx_ff) begin
            cont = block ? (beats_ff > 5'h01)
                         : (({1'b0, tx_count} + 6'h01) < {1'b0, cap});
          end else begin
            cont = (!block || beats_ff > 5'h01) && rx_count != 5'h00;
          end
          if (cont) begin
            nxt_state = ST_T1;
            nxt_mem_addr = mem_addr_ff + step;
            if (!dir_tx_ff) begin
              nxt_mem_wdata = rx_out.data;
              rx_pop = 1'b1;
            end
          end else begin
            nxt_state = ST_IDLE;
            nxt_mem_cyc = 1'b0;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_mem_cyc = 1'b0;
      end
    endcase
    // Ready is registered from the level after this edge, so it never overfills.
    nxt_rx_level = {1'b0, rx_count} + {5'h00, rx_push} - {5'h00, rx_pop};
    nxt_rx_ready = nxt_rx_level < {1'b0, cap};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      dir_tx_ff <= 1'b0;
      beats_ff <= 5'h00;
      wcnt_ff <= 2'h0;
      mem_cyc_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_wide_ff <= 1'b0;
      mem_addr_ff <= 32'h00000000;
      mem_wdata_ff <= 32'h00000000;
      rx_ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dir_tx_ff <= nxt_dir_tx;
      beats_ff <= nxt_beats;
      wcnt_ff <= nxt_wcnt;
      mem_cyc_ff <= nxt_mem_cyc;
      mem_we_ff <= nxt_mem_we;
      mem_wide_ff <= nxt_mem_wide;
      mem_addr_ff <= nxt_mem_addr;
      mem_wdata_ff <= nxt_mem_wdata;
      rx_ready_ff <= nxt_rx_ready;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign mem_cyc_o = mem_cyc_ff;
  assign mem_we_o = mem_we_ff;
  assign mem_wide_o = mem_wide_ff;
  assign mem_addr_o = mem_addr_ff;
  assign mem_wdata_o = mem_wdata_ff;
  assign rx_ready_o = rx_ready_ff;
  assign tx_valid_o = tx_ob.valid;
  assign tx_data_o = tx_ob.data;

endmodule

// ==== rtl/dftc_fifo.sv ====
// Flip-flop FIFO of 32-bit entries with a run-time capacity limit.
// Assumes cap_i does not shrink below the current fill level.
`timescale 1ns/1ps
module dftc_fifo import dftc_pkg::*; (
  input wire logic clk_i, // clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic [CNT_W-1:0] cap_i, // usable entries
  dftc_stream_if.snk in_s, // fill side
  dftc_stream_if.src out_s, // drain side
  output logic [CNT_W-1:0] count_o // fill level
);
  logic [DATA_W-1:0] mem_ff [FIFO_DEPTH];
  logic [DATA_W-1:0] nxt_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [CNT_W-1:0] count_ff, nxt_count;
  logic push, pop;

  assign in_s.ready = count_ff < cap_i;
  assign out_s.valid = count_ff != 5'h00;
  assign out_s.data = mem_ff[rd_ptr_ff];
  assign count_o = count_ff;
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  always_comb begin
    nxt_mem = mem_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    if (push) begin
      nxt_mem[wr_ptr_ff] = in_s.data;
      nxt_wr_ptr = wr_ptr_ff + 4'h1;
    end
    if (pop) begin
      nxt_rd_ptr = rd_ptr_ff + 4'h1;
    end
    if (push && !pop) begin
      nxt_count = count_ff + 5'h01;
    end else if (pop && !push) begin
      nxt_count = count_ff - 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    mem_ff <= nxt_mem;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_ff <= 4'h0;
      rd_ptr_ff <= 4'h0;
      count_ff <= 5'h00;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
  end
endmodule

// ==== rtl/dftc_skid.sv ====
// Two-entry buffer with registered outputs in front of the transmit consumer.
// Assumes the consumer may hold ready low for any number of cycles.
`timescale 1ns/1ps
module dftc_skid import dftc_pkg::*; (
  input wire logic clk_i, // clock
  input wire logic rst_i, // synchronous reset, high
  dftc_stream_if.snk in_s, // from transmit FIFO
  dftc_stream_if.src out_s // to consumer
);
  logic main_valid_ff, nxt_main_valid, spare_valid_ff, nxt_spare_valid;
  logic [DATA_W-1:0] main_data_ff, nxt_main_data, spare_data_ff, nxt_spare_data;
  logic take, drain;

  // Ready depends only on a flop, so a stall never loses a word in flight.
  assign in_s.ready = ~spare_valid_ff;
  assign out_s.valid = main_valid_ff;
  assign out_s.data = main_data_ff;
  assign take = in_s.valid & ~spare_valid_ff;
  assign drain = main_valid_ff & out_s.ready;

  always_comb begin
    nxt_main_valid = main_valid_ff;
    nxt_main_data = main_data_ff;
    nxt_spare_valid = spare_valid_ff;
    nxt_spare_data = spare_data_ff;
    if (drain) begin
      if (spare_valid_ff) begin
        nxt_main_data = spare_data_ff;
        nxt_spare_valid = 1'b0;
      end else if (take) begin
        nxt_main_data = in_s.data;
      end else begin
        nxt_main_valid = 1'b0;
      end
    end else if (take) begin
      if (!main_valid_ff) begin
        nxt_main_valid = 1'b1;
        nxt_main_data = in_s.data;
      end else begin
        nxt_spare_valid = 1'b1;
        nxt_spare_data = in_s.data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_valid_ff <= 1'b0;
      spare_valid_ff <= 1'b0;
      main_data_ff <= 32'h00000000;
      spare_data_ff <= 32'h00000000;
    end else begin
      main_valid_ff <= nxt_main_valid;
      spare_valid_ff <= nxt_spare_valid;
      main_data_ff <= nxt_main_data;
      spare_data_ff <= nxt_spare_data;
    end
  end
endmodule

// ==== shared/dftc_pkg.sv ====
// Constants shared by the DMA threshold engine, its FIFO and its output buffer.
// Assumes a 32-bit classic Wishbone register bus and a 32-bit memory data path.
package dftc_pkg;

  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam int PTR_W = 4;
  localparam int BYTE_W = 7;

  localparam logic [7:0] OFS_DATA_CFG = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RX_ADDR = 8'h0C;
  localparam logic [7:0] OFS_TX_ADDR = 8'h10;

  localparam int CFG_WAIT_LSB = 6;
  localparam int CFG_DW_BIT = 5;
  localparam int CFG_BMS_BIT = 4;
  localparam int CFG_RFT_LSB = 2;
  localparam int CFG_TFT_LSB = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;

  localparam int CTRL_RX_BIT = 0;
  localparam int CTRL_TX_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  localparam logic [BYTE_W-1:0] RX_THR_BYTES [4] = '{7'h04, 7'h08, 7'h10, 7'h18};
  localparam logic [BYTE_W-1:0] TX_THR_BYTES [4] = '{7'h08, 7'h10, 7'h18, 7'h1C};

  // FIFO capacity in transfer units: 32 bytes as words or as long words.
  localparam logic [CNT_W-1:0] CAP_WORD = 5'h10;
  localparam logic [CNT_W-1:0] CAP_LONG = 5'h08;

  localparam logic [31:0] STEP_WORD = 32'h00000002;
  localparam logic [31:0] STEP_LONG = 32'h00000004;
  localparam logic [31:0] MASK_WORD = 32'h0000FFFF;
  localparam logic [31:0] MASK_LONG = 32'hFFFFFFFF;

  typedef enum logic [1:0] {ST_IDLE, ST_T1, ST_T2} dftc_state_t;

endpackage

// ==== shared/dftc_stream_if.sv ====
// Valid/ready word stream between the engine's own modules.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface dftc_stream_if;
  import dftc_pkg::*;
  logic valid;
  logic ready;
  logic [DATA_W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// ==== sim/dftc_dma_props.sv ====
// Port-level assertions for the DMA threshold engine, bound into its top.
// Assumes the data configuration is only written while no burst runs.
`timescale 1ns/1ps
module dftc_dma_props import dftc_pkg::*; (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic wb_ack_o, // acknowledge
  input wire logic mem_cyc_o, // burst
  input wire logic mem_we_o, // direction
  input wire logic mem_wide_o, // width
  input wire logic [31:0] mem_addr_o, // address
  input wire logic mem_rdy_i // ready
);
  localparam logic [7:0] RXU [4] = '{8'h02, 8'h04, 8'h08, 8'h0C};
  localparam logic [7:0] TXU [4] = '{8'h04, 8'h08, 8'h0C, 8'h0E};
  logic [7:0] cfg_ff, nxt_cfg, len_ff, nxt_len, beats_ff, nxt_beats;
  logic [31:0] adr_ff;
  logic cyc_ff, newc;
  // A shadow of the configuration lets the checks follow the programmed counts.
  always_comb begin
    newc = mem_cyc_o && (!cyc_ff || mem_addr_o != adr_ff);
    nxt_cfg = cfg_ff;
    if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
        wb_adr_i == OFS_DATA_CFG) begin
      nxt_cfg = wb_dat_i[7:0];
    end
    nxt_len = !mem_cyc_o ? 8'h00 : newc ? 8'h01 : len_ff + 8'h01;
    nxt_beats = !mem_cyc_o ? 8'h00 : newc ? beats_ff + 8'h01 : beats_ff;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= CFG_RESET;
      len_ff <= 8'h00;
      beats_ff <= 8'h00;
    end else begin
      cfg_ff <= nxt_cfg;
      len_ff <= nxt_len;
      beats_ff <= nxt_beats;
    end
    cyc_ff <= mem_cyc_o;
    adr_ff <= mem_addr_o;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // The reset guard keeps values from before a short reset out of the checks.
  sequence s_beat_end;
    !$past(rst_i) && mem_cyc_o && $past(mem_cyc_o) && $changed(mem_addr_o);
  endsequence
  sequence s_burst_end;
    !$past(rst_i) && $fell(mem_cyc_o);
  endsequence
  sequence s_rx_block_end;
    s_burst_end ##0 ($past(mem_we_o) && cfg_ff[4]);
  endsequence
  sequence s_tx_block_end;
    s_burst_end ##0 (!$past(mem_we_o) && cfg_ff[4]);
  endsequence
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not acknowledged next cycle");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  chk_wait_len: assert property ((s_beat_end or s_burst_end) |->
    len_ff >= {6'h00, cfg_ff[7:6]} + 8'h02) else $error("memory cycle too short");
  chk_addr_ready: assert property (s_beat_end |-> $past(mem_rdy_i))
    else $error("address advanced without ready");
  chk_width_sel: assert property (mem_cyc_o |-> mem_wide_o == cfg_ff[5])
    else $error("transfer width differs from configuration");
  chk_dir_hold: assert property (mem_cyc_o && $past(mem_cyc_o) |-> $stable(mem_we_o))
    else $error("direction changed inside a burst");
  chk_rx_block: assert property (s_rx_block_end |->
    beats_ff == (RXU[cfg_ff[3:2]] >> cfg_ff[5])) else $error("receive block length wrong");
  chk_tx_block: assert property (s_tx_block_end |->
    beats_ff != 8'h00 && beats_ff <= (TXU[cfg_ff[1:0]] >> cfg_ff[5]))
    else $error("transmit block length wrong");
endmodule
bind dftc_dma_top dftc_dma_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o),
  .mem_wide_o(mem_wide_o), .mem_addr_o(mem_addr_o), .mem_rdy_i(mem_rdy_i));

// ==== sim/dftc_mem_model.sv ====
// System memory partner: answers each cycle after a programmable stall and logs traffic.
// Assumes address, direction and write data hold steady through each cycle.
`timescale 1ns/1ps
module dftc_mem_model import dftc_pkg::*; (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic mem_cyc_i, // burst active
  input wire logic mem_we_i, // write to memory
  input wire logic [31:0] mem_addr_i, // byte address
  input wire logic [31:0] mem_wdata_i, // write data
  input wire logic [7:0] stall_i, // clocks of a cycle before ready
  output logic mem_rdy_o, // ready
  output logic [31:0] mem_rdata_o // read data
);
  logic cyc_q = 1'b0;
  logic we_q = 1'b0;
  logic newc;
  logic [31:0] adr_q = 32'h0, wd_q = 32'h0;
  logic [7:0] cnt = 8'h00;
  logic [31:0] wq [$];
  logic [31:0] aq [$];
  int rd_n = 0;
  int bn = 0;
  initial begin
    mem_rdy_o = 1'b0;
    mem_rdata_o = 32'h0;
  end
  always @(posedge clk_i) begin
    newc = mem_cyc_i && (!cyc_q || mem_addr_i != adr_q);
    if (!rst_i && cyc_q && (newc || !mem_cyc_i)) begin
      if (we_q) begin
        wq.push_back(wd_q);
        aq.push_back(adr_q);
      end else begin
        rd_n++;
      end
    end
    if (newc && !cyc_q) bn++;
    cnt <= rst_i ? 8'h00 : newc ? 8'h01 : (cnt == 8'hFF ? cnt : cnt + 8'h01);
    mem_rdy_o <= !rst_i && mem_cyc_i && ((newc ? 8'h01 : cnt + 8'h01) >= stall_i);
    // Outside a read the data lines toggle, so a stale word is never taken as good.
    mem_rdata_o <= (mem_cyc_i && !mem_we_i) ? {~mem_addr_i[15:0], mem_addr_i[15:0]} : ~mem_rdata_o;
    cyc_q <= mem_cyc_i;
    we_q <= mem_we_i;
    adr_q <= mem_addr_i;
    wd_q <= mem_wdata_i;
  end
endmodule

// ==== sim/tb.sv ====
// Self-checking bench: registers, receive and transmit bursts of the DMA engine.
// Assumes the memory model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb;
  import dftc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, rx_valid_i = 1'b0, tx_ready_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, stall = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, rx_data_i = 32'h0;
  logic [31:0] wb_dat_o, mem_addr_o, mem_wdata_o, mem_rdata_i, tx_data_o;
  logic wb_ack_o, mem_cyc_o, mem_we_o, mem_wide_o, mem_rdy_i, rx_ready_o, tx_valid_o;
  int num_errors = 0, checked = 0, cycles = 0;
  always #2 clk_i = ~clk_i;
  dftc_dma_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o),
    .mem_wide_o(mem_wide_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .mem_rdy_i(mem_rdy_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i));
  dftc_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_cyc_i(mem_cyc_o), .mem_we_i(mem_we_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .stall_i(stall),
    .mem_rdy_o(mem_rdy_i), .mem_rdata_o(mem_rdata_i));
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // Entered just after a rising edge; leaves one idle cycle so requests never merge.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    chk(wb_ack_o === 1'b1, "no acknowledge");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic push(input logic [31:0] d);
    int n;
    n = 0;
    rx_valid_i <= 1'b1;
    rx_data_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (rx_ready_o !== 1'b1 && n < 100);
    rx_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic clr();
    i_mem.wq.delete();
    i_mem.aq.delete();
    i_mem.rd_n = 0;
    i_mem.bn = 0;
  endtask
  // The trailing quiet window catches any transfer beyond the expected count.
  task automatic wait_for(input int want, input logic is_wr);
    int n;
    n = 0;
    while ((is_wr ? i_mem.wq.size() : i_mem.rd_n) < want && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (40) @(posedge clk_i);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, OFS_DATA_CFG, 32'h0, q);
    chk(q === 32'h0, "configuration reset value");
    wr(OFS_DATA_CFG, 32'hFFFFFFFF);
    wb(1'b0, OFS_DATA_CFG, 32'h0, q);
    chk(q === 32'h000000FF, "configuration read back");
    wb_sel_i <= 4'h0;
    wr(OFS_DATA_CFG, 32'h0);
    wb_sel_i <= 4'hF;
    wb(1'b0, OFS_DATA_CFG, 32'h0, q);
    chk(q === 32'h000000FF, "write without byte enable ignored");
    wb(1'b0, 8'h20, 32'h0, q);
    chk(q === 32'h0, "unmapped read");
    wr(OFS_DATA_CFG, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_rx_block();
    logic [1:0] e;
    logic quiet;
    int thr;
    for (int c = 0; c < 4; c++) begin
      e = 2'(c);
      thr = (c == 0) ? 1 : (c == 1) ? 2 : (c == 2) ? 4 : 6;
      wr(OFS_DATA_CFG, {24'h0, e, 2'b11, e, 2'b00});
      wr(OFS_RX_ADDR, 32'h1000);
      clr();
      wr(OFS_CONTROL, 32'h1);
      for (int k = 0; k < thr - 1; k++) push(32'hC0DE0000 + 32'(c * 16 + k));
      quiet = 1'b1;
      repeat (30) begin
        @(posedge clk_i);
        if (mem_cyc_o !== 1'b0) quiet = 1'b0;
      end
      chk(quiet, "receive request below threshold");
      push(32'hC0DE0000 + 32'(c * 16 + thr - 1));
      wait_for(thr, 1'b1);
      chk(i_mem.wq.size() == thr, "receive block count");
      for (int k = 0; k < thr; k++) begin
        chk(i_mem.wq[k] === 32'hC0DE0000 + 32'(c * 16 + k), "receive word");
        chk(i_mem.aq[k] === 32'h1000 + 32'(4 * k), "receive address");
      end
      wr(OFS_CONTROL, 32'h0);
    end
    $display("test rx block done");
  endtask
  task automatic t_rx_fill();
    wr(OFS_DATA_CFG, 32'h0);
    wr(OFS_RX_ADDR, 32'h3000);
    clr();
    for (int k = 0; k < 5; k++) push(32'hBEEF0000 + 32'(k));
    wr(OFS_CONTROL, 32'h1);
    wait_for(5, 1'b1);
    chk(i_mem.wq.size() == 5 && i_mem.bn == 1, "receive empty mode burst");
    for (int k = 0; k < 5; k++) begin
      chk(i_mem.wq[k][15:0] === 16'(k), "receive 16-bit word");
      chk(i_mem.aq[k] === 32'h3000 + 32'(2 * k), "receive 16-bit address");
    end
    wr(OFS_CONTROL, 32'h0);
    $display("test rx fill done");
  endtask
  task automatic t_tx(input logic [7:0] cfg, input int exp, input int bursts);
    int n;
    logic hs;
    logic [31:0] d, a;
    stall <= 8'h03;
    wr(OFS_DATA_CFG, {24'h0, cfg});
    wr(OFS_TX_ADDR, 32'h2000);
    clr();
    wr(OFS_CONTROL, 32'h2);
    wait_for(exp, 1'b0);
    chk(i_mem.rd_n == exp, "transmit read count");
    if (bursts > 0) chk(i_mem.bn == bursts, "transmit burst split");
    wr(OFS_CONTROL, 32'h0);
    wb(1'b0, OFS_STATUS, 32'h0, d);
    chk(d[17:0] === {2'h2, 3'h0, 5'(exp - 2), 8'h00}, "status fill level");
    for (int k = 0; k < exp; k++) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
        hs = tx_valid_o === 1'b1 && tx_ready_i === 1'b1;
        d = tx_data_o;
        tx_ready_i <= n[0];
      end while (!hs && n < 50);
      a = 32'h2000 + (cfg[5] ? 32'(4 * k) : 32'(2 * k));
      chk(cfg[5] ? d === {~a[15:0], a[15:0]} : d[15:0] === a[15:0], "transmit word");
    end
    @(posedge clk_i);
    tx_ready_i <= 1'b0;
    $display("test tx done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("MISMATCH %0t timeout", $time);
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_rx_block();
    t_rx_fill();
    t_tx(8'h33, 10, 2);
    t_tx(8'h01, 18, 1);
    t_tx(8'h10, 8, 2);
    t_tx(8'h52, 18, 2);
    print_verdict();
  end
endmodule
